// >>> hdl/uart_to_spi_packet_bridge.sv
// Packet bridge: UART command packets in, SPI controller transfers out.
// Assumes one 40 MHz clock; all serial pins are asynchronous to it.
//
// Summary of operation
// - While idle, drop every byte until the start code arrives.
// - First header byte picks read or write; other values are refused.
// - Second header byte is N, the SPI byte count.
// - Read: send N dummy bytes on SPI, capture the N returned bytes.
// - Write: take exactly N data bytes and shift them out in order.
// - Payload at most 16 bytes; buffer holds payload plus header.
// - Host link at 9600 baud; each received byte raises one event.
// - SPI controller; rx request at one or more, tx request at two or fewer.
// - Each fault class stores its own distinct error code.
// - SPI fault sets the error flag and stops remaining bytes.
// - Stored error code is sent back to the host over UART.
`timescale 1ns/100ps
`default_nettype none
module uart_to_spi_packet_bridge #(
  parameter int BAUD_DIV = bridge_pkg::BAUD_DIV,
  parameter int TIMEOUT_CYC = bridge_pkg::GAP_TIMEOUT_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic uart_rx_pin,
  output logic uart_tx_pin,
  output logic spi_sclk,
  output logic spi_mosi,
  output logic spi_cs_n,
  input wire logic spi_miso,
  input wire logic spi_fault,
  output logic spi_rx_req,
  output logic spi_tx_req,
  output logic error_flag,
  output logic [7:0] error_code,
  output logic busy
);
  import bridge_pkg::*;

  bridge_state_t state_r, state_nxt;
  logic [7:0] pkt_mem [BUF_DEPTH];
  logic mem_we;
  logic [4:0] mem_addr;
  logic [7:0] mem_wdata;
  logic rx_valid, rx_frame_err, tx_start, tx_busy;
  logic [7:0] rx_data, tx_data;
  logic [4:0] len_r, len_nxt, idx_r, idx_nxt, cnt_r, cnt_nxt;
  logic is_read_r, is_read_nxt;
  logic [7:0] err_r, err_nxt;
  logic err_flag_r, err_flag_nxt;
  logic [19:0] gap_r, gap_nxt;
  logic miso_m_r, miso_s_r, flt_m_r, flt_s_r;
  logic spi_act_r, spi_act_nxt, sclk_r, sclk_nxt, cs_n_r, cs_n_nxt;
  logic [7:0] sh_r, sh_nxt, rsh_r, rsh_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [2:0] hc_r, hc_nxt;
  logic byte_done, spi_load;

  // ***************************************************************
  // Host UART
  // ***************************************************************
  host_serial_port #(.BAUD_DIV(BAUD_DIV)) host_serial_port (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .rx_pin(uart_rx_pin),
    .tx_pin(uart_tx_pin),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .rx_frame_err(rx_frame_err),
    .tx_start(tx_start),
    .tx_data(tx_data),
    .tx_busy(tx_busy)
  );

  // Synchronisers for the SPI-side pins
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      miso_m_r <= 1'b0;
      miso_s_r <= 1'b0;
      flt_m_r <= 1'b0;
      flt_s_r <= 1'b0;
    end else begin
      miso_m_r <= spi_miso;
      miso_s_r <= miso_m_r;
      flt_m_r <= spi_fault;
      flt_s_r <= flt_m_r;
    end
  end

  // ***************************************************************
  // Packet state machine
  // ***************************************************************
  // One byte per SPI load; next byte waits for the previous to finish
  assign spi_load = (state_r == ST_SPI) && !spi_act_r && !flt_s_r && (idx_r < len_r);
  // Reply and error bytes go out one at a time, only when the UART is free
  assign tx_start = !tx_busy && ((state_r == ST_ERR) ||
                    ((state_r == ST_REPLY) && (cnt_r < len_r)));
  assign tx_data = (state_r == ST_ERR) ? err_r : pkt_mem[5'(HDR_BYTES) + cnt_r];

  always_comb begin
    state_nxt = state_r;
    len_nxt = len_r;
    idx_nxt = idx_r;
    cnt_nxt = cnt_r;
    is_read_nxt = is_read_r;
    err_nxt = err_r;
    err_flag_nxt = err_flag_r;
    mem_we = 1'b0;
    mem_addr = RW_POS;
    mem_wdata = rx_data;
    gap_nxt = rx_valid ? 20'h00000 : gap_r + 20'h00001;
    unique case (state_r)
      ST_IDLE: begin
        idx_nxt = 5'h00;
        cnt_nxt = 5'h00;
        if (rx_valid && rx_data == START_CODE) begin
          state_nxt = ST_DIR;
          err_flag_nxt = 1'b0;
        end
      end
      ST_DIR: begin
        if (rx_valid) begin
          mem_we = 1'b1;
          mem_addr = RW_POS;
          if (rx_data == READ_CODE || rx_data == WRITE_CODE) begin
            is_read_nxt = (rx_data == READ_CODE);
            state_nxt = ST_LEN;
          end else begin
            err_nxt = ERR_UNDERFLOW;
            state_nxt = ST_ERR;
          end
        end
      end
      ST_LEN: begin
        if (rx_valid) begin
          mem_we = 1'b1;
          mem_addr = LEN_POS;
          if (rx_data > MAX_PAYLOAD) begin
            err_nxt = ERR_FULL;
            state_nxt = ST_ERR;
          end else begin
            len_nxt = rx_data[4:0];
            state_nxt = (is_read_r || rx_data == 8'h00) ? ST_SPI : ST_DATA;
          end
        end
      end
      ST_DATA: begin
        if (rx_valid) begin
          mem_we = 1'b1;
          mem_addr = 5'(HDR_BYTES) + cnt_r;
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_r + 5'h01 == len_r) begin
            state_nxt = ST_SPI;
          end
        end
      end
      ST_SPI: begin
        if (byte_done) begin
          mem_we = is_read_r;
          mem_addr = 5'(HDR_BYTES) + idx_r;
          mem_wdata = rsh_r;
          idx_nxt = idx_r + 5'h01;
        end
        if (flt_s_r) begin
          err_nxt = ERR_SPI_FAULT;
          state_nxt = ST_ERR;
        end else if (rx_valid) begin
          err_nxt = ERR_OVERFLOW;
          state_nxt = ST_ERR;
        end else if (!spi_act_r && idx_r == len_r) begin
          cnt_nxt = 5'h00;
          state_nxt = is_read_r ? ST_REPLY : ST_IDLE;
        end
      end
      ST_REPLY: begin
        if (tx_start) begin
          cnt_nxt = cnt_r + 5'h01;
        end
        if (!tx_busy && cnt_r == len_r) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_ERR: begin
        err_flag_nxt = 1'b1;
        if (tx_start) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // framing and gap faults while a packet is open
    if (state_r == ST_DIR || state_r == ST_LEN || state_r == ST_DATA) begin
      if (rx_frame_err) begin
        err_nxt = ERR_PARITY;
        state_nxt = ST_ERR;
        mem_we = 1'b0;
      end else if (gap_r >= 20'(TIMEOUT_CYC)) begin
        err_nxt = ERR_TIMEOUT;
        state_nxt = ST_ERR;
        mem_we = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      len_r <= 5'h00;
      idx_r <= 5'h00;
      cnt_r <= 5'h00;
      is_read_r <= 1'b0;
      err_r <= ERR_NONE;
      err_flag_r <= 1'b0;
      gap_r <= 20'h00000;
    end else begin
      state_r <= state_nxt;
      len_r <= len_nxt;
      idx_r <= idx_nxt;
      cnt_r <= cnt_nxt;
      is_read_r <= is_read_nxt;
      err_r <= err_nxt;
      err_flag_r <= err_flag_nxt;
      gap_r <= gap_nxt;
    end
  end

  // Packet buffer; contents need no reset
  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      pkt_mem[mem_addr] <= mem_wdata;
    end
  end

  // ***************************************************************
  // SPI controller, mode 0, MSB first
  // ***************************************************************
  assign byte_done = spi_act_r && sclk_r && hc_r == 3'h0 && bit_r == 3'h7;

  always_comb begin
    spi_act_nxt = spi_act_r;
    sclk_nxt = sclk_r;
    sh_nxt = sh_r;
    rsh_nxt = rsh_r;
    bit_nxt = bit_r;
    hc_nxt = hc_r;
    cs_n_nxt = (state_nxt != ST_SPI);
    if (spi_load) begin
      // write bytes in order, dummy bytes on read
      sh_nxt = is_read_r ? DUMMY_BYTE : pkt_mem[5'(HDR_BYTES) + idx_r];
      spi_act_nxt = 1'b1;
      bit_nxt = 3'h0;
      hc_nxt = 3'(SPI_HALF - 1);
    end else if (spi_act_r) begin
      if (hc_r != 3'h0) begin
        hc_nxt = hc_r - 3'h1;
      end else begin
        hc_nxt = 3'(SPI_HALF - 1);
        sclk_nxt = ~sclk_r;
        if (!sclk_r) begin
          rsh_nxt = {rsh_r[6:0], miso_s_r};
        end else begin
          sh_nxt = {sh_r[6:0], 1'b0};
          bit_nxt = bit_r + 3'h1;
          spi_act_nxt = (bit_r != 3'h7);
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      spi_act_r <= 1'b0;
      sclk_r <= 1'b0;
      cs_n_r <= 1'b1;
      sh_r <= 8'h00;
      rsh_r <= 8'h00;
      bit_r <= 3'h0;
      hc_r <= 3'h0;
    end else begin
      spi_act_r <= spi_act_nxt;
      sclk_r <= sclk_nxt;
      cs_n_r <= cs_n_nxt;
      sh_r <= sh_nxt;
      rsh_r <= rsh_nxt;
      bit_r <= bit_nxt;
      hc_r <= hc_nxt;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign spi_sclk = sclk_r;
  assign spi_mosi = sh_r[7];
  assign spi_cs_n = cs_n_r;
  // request thresholds on bytes pending each way
  assign spi_tx_req = (state_r == ST_SPI) && ((len_r - idx_r) <= 5'(TX_REQ_LEVEL));
  assign spi_rx_req = is_read_r && ((idx_r - cnt_r) >= 5'(RX_REQ_LEVEL)) &&
                      (state_r == ST_SPI || state_r == ST_REPLY);
  assign error_flag = err_flag_r;
  assign error_code = err_r;
  assign busy = (state_r != ST_IDLE);

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_idle_drop: assert property ((state_r == ST_IDLE) && !(rx_valid && rx_data == START_CODE)
    |=> state_r == ST_IDLE) else $error("left idle without start code");
  chk_dir_refuse: assert property ((state_r == ST_DIR) && rx_valid && !rx_frame_err &&
    rx_data != READ_CODE && rx_data != WRITE_CODE |=> state_r == ST_ERR && err_r == ERR_UNDERFLOW)
    else $error("bad direction code accepted");
  chk_len_count: assert property ((state_r == ST_SPI) && !flt_s_r && !rx_valid && !spi_act_r &&
    idx_r == len_r |=> state_r != ST_SPI) else $error("SPI phase overran length");
  chk_read_dummy: assert property (spi_load && is_read_r |=> sh_r == DUMMY_BYTE && !spi_cs_n)
    else $error("read did not shift dummy byte");
  chk_write_order: assert property (spi_load && !is_read_r
    |=> sh_r == pkt_mem[5'(HDR_BYTES) + $past(idx_r)]) else $error("write byte out of order");
  chk_len_limit: assert property ((state_r == ST_LEN) && rx_valid && !rx_frame_err &&
    rx_data > MAX_PAYLOAD |=> err_r == ERR_FULL) else $error("oversize length accepted");
  chk_byte_time: assert property (spi_load |-> ##[62:66] byte_done)
    else $error("SPI byte length wrong");
  chk_fault_code: assert property ((state_r == ST_SPI) && flt_s_r
    |=> state_r == ST_ERR && err_r == ERR_SPI_FAULT) else $error("SPI fault not recorded");
  chk_fault_stop: assert property ((state_r == ST_SPI) && flt_s_r |=> !spi_load [*2])
    else $error("SPI kept loading after fault");
  chk_err_report: assert property ((state_r == ST_ERR) && !tx_busy
    |-> tx_start && tx_data == err_r ##1 state_r == ST_IDLE && error_flag)
    else $error("error code not sent");
  chk_reply_idle: assert property ((state_r == ST_REPLY) && !tx_busy && cnt_r == len_r
    |=> state_r == ST_IDLE) else $error("reply did not return to idle");

  cov_read_done: cover property ((state_r == ST_REPLY) ##1 (state_r == ST_IDLE));
  cov_write_done: cover property ((state_r == ST_SPI) && !is_read_r ##1 (state_r == ST_IDLE));
  cov_err_sent: cover property ((state_r == ST_ERR) && tx_start);
  cov_full_pkt: cover property ((state_r == ST_LEN) && rx_valid && rx_data == MAX_PAYLOAD);
endmodule
`default_nettype wire

// >>> hdl/bridge_pkg.sv
// Constants, codes and states shared by the UART to SPI packet bridge.
// Assumes a single 40 MHz clock and a synchronous active-low reset.
package bridge_pkg;
  // ***************************************************************
  // Clock and link timing
  // ***************************************************************
  localparam int CLK_HZ = 40_000_000;
  localparam int BAUD_RATE = 9600;
  localparam int BAUD_DIV = CLK_HZ / BAUD_RATE; // Bit period rounds down
  localparam int SPI_HALF = 4; // Cycles per SCLK half period, 5 MHz
  localparam int GAP_TIMEOUT_MS = 10; // Longest gap between packet bytes
  localparam int GAP_TIMEOUT_CYC = (CLK_HZ / 1000) * GAP_TIMEOUT_MS;

  // ***************************************************************
  // Packet format
  // ***************************************************************
  localparam logic [7:0] START_CODE = 8'hf8;
  localparam logic [7:0] READ_CODE = 8'hfa;
  localparam logic [7:0] WRITE_CODE = 8'hfb;
  localparam logic [7:0] DUMMY_BYTE = 8'h00;
  localparam int HDR_BYTES = 2;
  localparam logic [4:0] RW_POS = 5'h00;
  localparam logic [4:0] LEN_POS = 5'h01;
  localparam logic [7:0] MAX_PAYLOAD = 8'h10;
  localparam int BUF_DEPTH = 16 + HDR_BYTES;
  localparam int TX_REQ_LEVEL = 2;
  localparam int RX_REQ_LEVEL = 1;

  // ***************************************************************
  // Error codes, ASCII digits so a terminal can show them
  // ***************************************************************
  localparam logic [7:0] ERR_NONE = 8'h30;
  localparam logic [7:0] ERR_TIMEOUT = 8'h31;
  localparam logic [7:0] ERR_PARITY = 8'h32;
  localparam logic [7:0] ERR_OVERFLOW = 8'h33;
  localparam logic [7:0] ERR_FULL = 8'h34;
  localparam logic [7:0] ERR_UNDERFLOW = 8'h35;
  localparam logic [7:0] ERR_SPI_FAULT = 8'h36;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DIR = 3'b001,
    ST_LEN = 3'b010,
    ST_DATA = 3'b011,
    ST_SPI = 3'b100,
    ST_REPLY = 3'b101,
    ST_ERR = 3'b110
  } bridge_state_t;
endpackage

// >>> hdl/host_serial_port.sv
// Host-facing UART: 8 data bits, no parity, one stop bit.
// Assumes rx_pin is asynchronous; tx_start is only raised while tx_busy is low.
`timescale 1ns/100ps
`default_nettype none
module host_serial_port #(
  parameter int BAUD_DIV = bridge_pkg::BAUD_DIV
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic rx_pin,
  output logic tx_pin,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_frame_err,
  input wire logic tx_start,
  input wire logic [7:0] tx_data,
  output logic tx_busy
);
  import bridge_pkg::*;

  logic rx_m_r, rx_s_r;
  logic [15:0] rx_cnt_r, rx_cnt_nxt, tx_cnt_r, tx_cnt_nxt;
  logic [3:0] rx_bit_r, rx_bit_nxt, tx_bit_r, tx_bit_nxt;
  logic [7:0] rx_sh_r, rx_sh_nxt;
  logic [9:0] tx_sh_r, tx_sh_nxt;
  logic rx_act_r, rx_act_nxt, tx_act_r, tx_act_nxt;
  logic rx_valid_r, rx_valid_nxt, rx_err_r, rx_err_nxt;

  // ***************************************************************
  // Receiver
  // ***************************************************************
  // Two-stage synchroniser; only rx_s_r is looked at
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rx_m_r <= 1'b1;
      rx_s_r <= 1'b1;
    end else begin
      rx_m_r <= rx_pin;
      rx_s_r <= rx_m_r;
    end
  end

  // Sample mid-bit; start bit counted as bit 0, stop bit as bit 9
  always_comb begin
    rx_cnt_nxt = rx_cnt_r;
    rx_bit_nxt = rx_bit_r;
    rx_sh_nxt = rx_sh_r;
    rx_act_nxt = rx_act_r;
    rx_valid_nxt = 1'b0;
    rx_err_nxt = 1'b0;
    if (!rx_act_r) begin
      if (!rx_s_r) begin
        rx_act_nxt = 1'b1;
        rx_cnt_nxt = 16'((BAUD_DIV / 2) - 1);
        rx_bit_nxt = 4'h0;
      end
    end else if (rx_cnt_r != 16'h0000) begin
      rx_cnt_nxt = rx_cnt_r - 16'h0001;
    end else begin
      rx_cnt_nxt = 16'(BAUD_DIV - 1);
      rx_bit_nxt = rx_bit_r + 4'h1;
      if (rx_bit_r == 4'h0) begin
        rx_act_nxt = ~rx_s_r; // Glitch, not a real start bit
      end else if (rx_bit_r == 4'h9) begin
        rx_act_nxt = 1'b0;
        rx_valid_nxt = rx_s_r;
        rx_err_nxt = ~rx_s_r;
      end else begin
        rx_sh_nxt = {rx_s_r, rx_sh_r[7:1]};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rx_cnt_r <= 16'h0000;
      rx_bit_r <= 4'h0;
      rx_sh_r <= 8'h00;
      rx_act_r <= 1'b0;
      rx_valid_r <= 1'b0;
      rx_err_r <= 1'b0;
    end else begin
      rx_cnt_r <= rx_cnt_nxt;
      rx_bit_r <= rx_bit_nxt;
      rx_sh_r <= rx_sh_nxt;
      rx_act_r <= rx_act_nxt;
      rx_valid_r <= rx_valid_nxt;
      rx_err_r <= rx_err_nxt;
    end
  end

  assign rx_valid = rx_valid_r;
  assign rx_data = rx_sh_r;
  assign rx_frame_err = rx_err_r;

  // ***************************************************************
  // Transmitter
  // ***************************************************************
  always_comb begin
    tx_cnt_nxt = tx_cnt_r;
    tx_bit_nxt = tx_bit_r;
    tx_sh_nxt = tx_sh_r;
    tx_act_nxt = tx_act_r;
    if (!tx_act_r) begin
      if (tx_start) begin
        tx_act_nxt = 1'b1;
        tx_sh_nxt = {1'b1, tx_data, 1'b0};
        tx_cnt_nxt = 16'(BAUD_DIV - 1);
        tx_bit_nxt = 4'h0;
      end
    end else if (tx_cnt_r != 16'h0000) begin
      tx_cnt_nxt = tx_cnt_r - 16'h0001;
    end else begin
      tx_cnt_nxt = 16'(BAUD_DIV - 1);
      tx_sh_nxt = {1'b1, tx_sh_r[9:1]};
      tx_bit_nxt = tx_bit_r + 4'h1;
      if (tx_bit_r == 4'h9) begin
        tx_act_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_cnt_r <= 16'h0000;
      tx_bit_r <= 4'h0;
      tx_sh_r <= 10'h3ff;
      tx_act_r <= 1'b0;
    end else begin
      tx_cnt_r <= tx_cnt_nxt;
      tx_bit_r <= tx_bit_nxt;
      tx_sh_r <= tx_sh_nxt;
      tx_act_r <= tx_act_nxt;
    end
  end

  assign tx_pin = tx_sh_r[0];
  assign tx_busy = tx_act_r;

  chk_rx_pulse_once: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rx_valid |=> !rx_valid) else $error("receive event longer than one cycle");
endmodule
`default_nettype wire

// >>> testbench/uart_host_model.sv
// UART host model: sends command packets, collects reply bytes.
// Assumes 8N1 framing with a bit time of BAUD_DIV ref_clk cycles.
`timescale 1ns/100ps
`default_nettype none
module uart_host_model #(
  parameter int BAUD_DIV = 16
) (
  input wire logic ref_clk,
  output logic tx_line,
  input wire logic rx_line
);
  logic [7:0] rx_q[$];
  logic [7:0] sh;

  // ***************************************************************
  // Command side
  // ***************************************************************
  initial tx_line = 1'b1;

  // caller picks each byte and its stop bit, one 10-bit frame per byte
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] fr;
    fr = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge ref_clk);
      tx_line = fr[i];
      repeat (BAUD_DIV - 1) @(negedge ref_clk);
    end
    @(negedge ref_clk);
    tx_line = 1'b1;
  endtask

  // ***************************************************************
  // Reply side
  // ***************************************************************
  // Sample mid-bit so edge jitter of a cycle does no harm
  initial begin
    forever begin
      @(negedge rx_line);
      repeat (BAUD_DIV / 2) @(posedge ref_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BAUD_DIV) @(posedge ref_clk);
        sh = {rx_line, sh[7:1]};
      end
      repeat (BAUD_DIV) @(posedge ref_clk);
      rx_q.push_back(sh);
    end
  end
endmodule
`default_nettype wire

// >>> testbench/uart_to_spi_packet_bridge_tb.sv
// Self-checking bench for the UART to SPI packet bridge.
// Assumes a shortened bit time and gap timeout; SPI peripheral is modelled here.
`timescale 1ns/100ps
`default_nettype none
module uart_to_spi_packet_bridge_tb;
  import bridge_pkg::*;
  localparam int BD = 16;
  localparam int TO = 400;
  logic ref_clk, rst_n, host_tx, spi_fault, seen_rx, seen_tx;
  logic uart_tx_pin, spi_sclk, spi_mosi, spi_cs_n, spi_rx_req, spi_tx_req, error_flag, busy;
  logic [7:0] error_code, mosi_sh;
  logic [7:0] mosi_q[$];
  logic [15:0] miso_sr;
  wire logic spi_miso;
  int n_fail, checked, bitn;

  uart_to_spi_packet_bridge #(.BAUD_DIV(BD), .TIMEOUT_CYC(TO)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .uart_rx_pin(host_tx), .uart_tx_pin(uart_tx_pin),
    .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_cs_n(spi_cs_n), .spi_miso(spi_miso),
    .spi_fault(spi_fault), .spi_rx_req(spi_rx_req), .spi_tx_req(spi_tx_req),
    .error_flag(error_flag), .error_code(error_code), .busy(busy));
  uart_host_model #(.BAUD_DIV(BD)) host (
    .ref_clk(ref_clk), .tx_line(host_tx), .rx_line(uart_tx_pin));

  // ***************************************************************
  // Clock, SPI peripheral and monitors
  // ***************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Deselected MISO shows the inverse, never a stale bit
  assign spi_miso = spi_cs_n ? ~miso_sr[15] : miso_sr[15];
  initial miso_sr = 16'h0000;
  always @(negedge spi_cs_n) begin
    bitn = 0;
    @(negedge ref_clk);
    miso_sr = 16'h5ac3;
  end
  always @(negedge spi_sclk) begin
    @(negedge ref_clk);
    miso_sr = {miso_sr[14:0], ~miso_sr[15]};
  end
  always @(posedge spi_sclk) begin
    if (!spi_cs_n) begin
      mosi_sh = {mosi_sh[6:0], spi_mosi};
      bitn++;
      if (bitn == 8) begin
        mosi_q.push_back(mosi_sh);
        bitn = 0;
      end
    end
  end
  // Requests are combinational from registers; look once they have settled
  always @(negedge ref_clk) begin
    if (spi_rx_req === 1'b1) seen_rx = 1'b1;
    if (spi_tx_req === 1'b1) seen_tx = 1'b1;
  end

  // ***************************************************************
  // Shared tasks
  // ***************************************************************
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pkt(input logic [7:0] b[$], input logic stop_last);
    foreach (b[i]) host.send(b[i], (i == b.size() - 1) ? stop_last : 1'b1);
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 3000) begin
      @(negedge ref_clk);
      k++;
    end
    chk("busy", 8'h00, {7'h0, busy});
  endtask
  task automatic reply(input logic [7:0] exp, input int lim);
    int k;
    k = 0;
    while (host.rx_q.size() == 0 && k < lim) begin
      @(negedge ref_clk);
      k++;
    end
    chk("reply", exp, (host.rx_q.size() > 0) ? host.rx_q.pop_front() : 8'hxx);
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  // Error packet; optional SPI fault once the transfer is under way
  task automatic err_case(input logic [7:0] b[$], input logic stop_last, input logic fault,
                          input logic [7:0] code, input int lim);
    mosi_q.delete();
    pkt(b, stop_last);
    if (fault) begin
      repeat (20) @(negedge ref_clk);
      spi_fault = 1'b1;
    end
    reply(code, lim);
    spi_fault = 1'b0;
    chk("error_flag", 8'h01, {7'h0, error_flag});
    chk("error_code", code, error_code);
    if (fault) chk("spi_stopped", 8'h01, {7'h0, mosi_q.size() < 4});
    wait_idle();
    $display("test error %h done", code);
  endtask
  task automatic t_write();
    pkt('{8'h12, 8'hfb}, 1'b1);
    repeat (40) @(negedge ref_clk);
    chk("idle_drop", 8'h00, {7'h0, busy});
    mosi_q.delete();
    seen_tx = 1'b0;
    pkt('{START_CODE, WRITE_CODE, 8'h02, 8'ha5, 8'h3c}, 1'b1);
    chk("flag_cleared", 8'h00, {7'h0, error_flag});
    wait_idle();
    chk("mosi_count", 8'h02, 8'(mosi_q.size()));
    chk("mosi_d0", 8'ha5, mosi_q[0]);
    chk("mosi_d1", 8'h3c, mosi_q[1]);
    chk("tx_req_seen", 8'h01, {7'h0, seen_tx});
    chk("no_reply", 8'h00, 8'(host.rx_q.size()));
    $display("test write done");
  endtask
  task automatic t_read();
    mosi_q.delete();
    seen_rx = 1'b0;
    pkt('{START_CODE, READ_CODE, 8'h02}, 1'b1);
    reply(8'h5a, 3000);
    reply(8'hc3, 3000);
    chk("dummy_count", 8'h02, 8'(mosi_q.size()));
    chk("dummy_byte", DUMMY_BYTE, mosi_q[1]);
    chk("rx_req_seen", 8'h01, {7'h0, seen_rx});
    wait_idle();
    $display("test read done");
  endtask

  // ***************************************************************
  // Main sequence and watchdog
  // ***************************************************************
  initial begin
    rst_n = 1'b0;
    spi_fault = 1'b0;
    n_fail = 0;
    checked = 0;
    bitn = 0;
    seen_rx = 1'b0;
    seen_tx = 1'b0;
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    chk("code_reset", ERR_NONE, error_code);
    err_case('{START_CODE, 8'h55}, 1'b1, 1'b0, ERR_UNDERFLOW, 2000);
    t_write();
    t_read();
    err_case('{START_CODE, WRITE_CODE, 8'h11}, 1'b1, 1'b0, ERR_FULL, 2000);
    err_case('{START_CODE, WRITE_CODE}, 1'b0, 1'b0, ERR_PARITY, 2000);
    err_case('{START_CODE}, 1'b1, 1'b0, ERR_TIMEOUT, TO + 2000);
    err_case('{START_CODE, WRITE_CODE, 8'h04, 8'h11, 8'h22, 8'h33, 8'h44}, 1'b1, 1'b1,
             ERR_SPI_FAULT, 2000);
    finish_test();
  end
  // Scenarios need well under 20000 cycles
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_fail++;
    finish_test();
  end
endmodule
`default_nettype wire
